// file: logic/gpp_defs.vh
// Register offsets, field positions and codes of the GPIO port
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH
// Word offsets (word index = offset, byte address = 4 * offset)
`define GPP_OFS_DIR      8'h00
`define GPP_OFS_DRIVE_ENABLE_SET   8'h01
`define GPP_OFS_DRIVE_ENABLE_CLEAR   8'h02
`define GPP_OFS_DRIVE_ENABLE_TOGGLE   8'h03
`define GPP_OFS_OUT      8'h04
`define GPP_OFS_LEVEL_SET_STROBE   8'h05
`define GPP_OFS_LEVEL_CLEAR_STROBE   8'h06
`define GPP_OFS_LEVEL_TOGGLE_STROBE   8'h07
`define GPP_OFS_IN       8'h08
`define GPP_OFS_FLAGS    8'h09
`define GPP_OFS_CFG0     8'h10
// Fast alias block: dir, out, in, flags at alias base + 0..3
`define GPP_OFS_ALIAS    8'h20
// Interrupt status register of this block
`define GPP_OFS_STAT     8'h24
// Per-pin config fields
`define GPP_CFG_INV      7
`define GPP_CFG_PULL     3
`define GPP_CFG_ISC_HI   2
`define GPP_CFG_ISC_LO   0
// Sense codes
`define GPP_ISC_ANY      3'h1
`define GPP_ISC_UP       3'h2
`define GPP_ISC_DOWN     3'h3
`define GPP_ISC_OFF      3'h4
`define GPP_ISC_LOW      3'h5
// Dead time after a flag for synchronously sensed pins
`define GPP_DEAD_CYC     2'h3
`define GPP_CFG_RST      8'h00
`endif

// file: logic/gpp_port.v
// Eight-bit GPIO port with strobe registers, alias block and pin sensing
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
`include "gpp_defs.vh"
//
// Contract
// - Each pin has one drive-enable bit and one driven-level bit.
// - sampled_level is pin resynchronised; synchroniser held when sense is off.
// - Pin value readable in either direction unless sense is off.
// - Reset releases all pins and keeps input buffers enabled.
// - Pin n config register sits at offset 0x10 plus n.
// - Writing 1 to drive_enable_set sets that direction bit only.
// - Writing 1 to drive_enable_clear clears that direction bit only.
// - Writing 1 to drive_enable_toggle inverts that direction bit.
// - Writing 1 to level_set_strobe sets that output bit.
// - Writing 1 to level_clear_strobe clears that output bit.
// - Writing 1 to toggle strobe or sampled_level inverts output bit.
// - Alias copies of dir, out, in, flags act like regular ones.
// - polarity_flip inverts input and output path of the pin.
// - Flipping polarity makes an edge seen by sensing and events.
// - weak_high_resistor bit enables the pin pull-up.
// - sense_select picks any, up, down, low level or disabled.
// - Edge from polarity change with sense change may be ignored.
// - Pending edge may be raised when input is re-enabled.
// - Pending interrupt may be dropped when sense setting changes.
// - Async pins wake on all senses; others on any edge or low only.
// - Configured condition sets the pin flag in event_flag_reg.
// - Interrupt request stands while any flag is set.
// - Event output follows pin value, zero while input disabled.
// - Synchronous pins block new flags three cycles after previous.
module gpp_port #(
  parameter        NPIN     = 8,
  parameter [7:0]  ASYNC_MASK = 8'h04
) (
  input  wire            clk_i,
  input  wire            rst_i,
  input  wire            wb_cyc_i,
  input  wire            wb_stb_i,
  input  wire            wb_we_i,
  input  wire [7:0]      wb_adr_i,
  input  wire [3:0]      wb_sel_i,
  input  wire [31:0]     wb_dat_i,
  output reg  [31:0]     wb_dat_o,
  output reg             wb_ack_o,
  input  wire [NPIN-1:0] pin_in_i,
  output reg  [NPIN-1:0] pin_out_o,
  output reg  [NPIN-1:0] pin_oe_o,
  output reg  [NPIN-1:0] pin_pullup_o,
  output reg  [NPIN-1:0] pin_ibuf_en_o,
  output reg  [NPIN-1:0] pin_event_o,
  output reg             irq_o,
  output reg             wake_o
);

////////////////////////////////////////////////////////////////////////////
  reg  [NPIN-1:0] dir_q;
  reg  [NPIN-1:0] lvl_q;
  reg  [NPIN-1:0] flag_q;
  reg  [7:0]      cfg_q [0:NPIN-1];
  reg  [NPIN-1:0] sync1_q;
  reg  [NPIN-1:0] sync2_q;
  reg  [NPIN-1:0] prev_q;
  reg  [NPIN-1:0] senoff_q;
  reg  [1:0]      dead_q [0:NPIN-1];
  reg  [NPIN-1:0] flag_d;
  reg  [NPIN-1:0] hit;
  reg  [NPIN-1:0] inv;
  reg  [NPIN-1:0] senoff;
  reg  [NPIN-1:0] wake_hit;
  reg  [31:0]     rd_d;
  reg  [7:0]      wr8;
  reg             wr_dir;
  reg             wr_drive_enable_set;
  reg             wr_drive_enable_clear;
  reg             wr_drive_enable_toggle;
  reg             wr_out;
  reg             wr_level_set_strobe;
  reg             wr_level_clear_strobe;
  reg             wr_level_toggle_strobe;
  reg             wr_flags;
  reg             wr_cfg;
  wire            acc;
  wire            wr;
  integer         i;
  integer         j;
  integer         m;
  integer         n;
  integer         r;
  integer         p;

  // Register words (byte address = 4 * word):
  //   0x00 direction, 0x01..0x03 its set, clear and toggle strobes
  //   0x04 output level, 0x05..0x07 its set, clear and toggle strobes
  //   0x08 sampled level; writing ones toggles the output level
  //   0x09 event flags, write one to clear
  //   0x10..0x17 per-pin configuration
  //   0x20..0x23 alias of direction, level, sampled level and flags
  //   0x24 status, bit 0 mirrors the interrupt request
  // Configuration byte: bit 7 invert, bit 3 pull-up, bits 2:0 sense
  // Limitation: asynchronous pins are only marked by ASYNC_MASK; the
  // wake pulse still needs the clock, so waking with no clock running
  // has to be built around this block.

  // Byte address to word index; sub-word offsets are not decoded
  function [7:0] widx;
    input [7:0] a;
    begin
      widx = {2'h0, a[7:2]};
    end
  endfunction

  // Selects a per-pin config field
  function [2:0] isc_of;
    input [7:0] c;
    begin
      isc_of = c[`GPP_CFG_ISC_HI:`GPP_CFG_ISC_LO];
    end
  endfunction

  // True when the byte address hits the given word exactly
  function at_word;
    input [7:0] a;
    input [7:0] ofs;
    begin
      at_word = (a[7:2] == ofs[5:0]) && (a[1:0] == 2'h0);
    end
  endfunction

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = acc & wb_we_i & wb_sel_i[0];

////////////////////////////////////////////////////////////////////////////
  always @* begin
    wr8 = wb_dat_i[7:0];
    for (j = 0; j < NPIN; j = j + 1) begin
      inv[j]    = cfg_q[j][`GPP_CFG_INV];
      senoff[j] = (isc_of(cfg_q[j]) == `GPP_ISC_OFF);
    end
  end

  // Sense on the synchronised, polarity-corrected level
  always @* begin
    hit      = {NPIN{1'b0}};
    wake_hit = {NPIN{1'b0}};
    for (i = 0; i < NPIN; i = i + 1) begin
      case (isc_of(cfg_q[i]))
        `GPP_ISC_ANY:  hit[i] = sync2_q[i] ^ prev_q[i];
        `GPP_ISC_UP:   hit[i] = sync2_q[i] & ~prev_q[i];
        `GPP_ISC_DOWN: hit[i] = ~sync2_q[i] & prev_q[i];
        `GPP_ISC_LOW:  hit[i] = ~sync2_q[i];
        default:       hit[i] = 1'b0;
      endcase
      // A pin leaving the off state is blocked one cycle, then compares against its frozen level
      if (senoff_q[i] | senoff[i])
        hit[i] = 1'b0;
      if (!ASYNC_MASK[i] && dead_q[i] != 2'h0)
        hit[i] = 1'b0;
      case (isc_of(cfg_q[i]))
        `GPP_ISC_ANY, `GPP_ISC_LOW: wake_hit[i] = hit[i];
        `GPP_ISC_UP, `GPP_ISC_DOWN: wake_hit[i] = hit[i] & ASYNC_MASK[i];
        default:                    wake_hit[i] = 1'b0;
      endcase
    end
  end

  // Set beats a clear written in the same cycle
  always @* begin
    flag_d = flag_q;
    if (wr_flags)
      flag_d = flag_q & ~wr8;
    flag_d = flag_d | hit;
  end

////////////////////////////////////////////////////////////////////////////
  // Write decode; each word has one strobe and at most one fires
  always @* begin
    wr_dir    = 1'b0;
    wr_drive_enable_set = 1'b0;
    wr_drive_enable_clear = 1'b0;
    wr_drive_enable_toggle = 1'b0;
    wr_out    = 1'b0;
    wr_level_set_strobe = 1'b0;
    wr_level_clear_strobe = 1'b0;
    wr_level_toggle_strobe = 1'b0;
    wr_flags  = 1'b0;
    wr_cfg    = 1'b0;
    if (wr) begin
      if (at_word(wb_adr_i, `GPP_OFS_DIR)
          || at_word(wb_adr_i, `GPP_OFS_ALIAS)) begin
        wr_dir = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_DRIVE_ENABLE_SET)) begin
        wr_drive_enable_set = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_DRIVE_ENABLE_CLEAR)) begin
        wr_drive_enable_clear = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_DRIVE_ENABLE_TOGGLE)) begin
        wr_drive_enable_toggle = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_OUT)
                   || at_word(wb_adr_i, `GPP_OFS_ALIAS + 8'h01)) begin
        wr_out = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_LEVEL_SET_STROBE)) begin
        wr_level_set_strobe = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_LEVEL_CLEAR_STROBE)) begin
        wr_level_clear_strobe = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_LEVEL_TOGGLE_STROBE)
                   || at_word(wb_adr_i, `GPP_OFS_IN)
                   || at_word(wb_adr_i, `GPP_OFS_ALIAS + 8'h02)) begin
        wr_level_toggle_strobe = 1'b1;
      end else if (at_word(wb_adr_i, `GPP_OFS_FLAGS)
                   || at_word(wb_adr_i, `GPP_OFS_ALIAS + 8'h03)) begin
        wr_flags = 1'b1;
      end else if (widx(wb_adr_i) >= `GPP_OFS_CFG0
                   && widx(wb_adr_i) < `GPP_OFS_CFG0 + 8'h08) begin
        wr_cfg = 1'b1;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////
  // Input path: two flops, then the previous level for edge detection
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q  <= {NPIN{1'b0}};
      sync2_q  <= {NPIN{1'b0}};
      prev_q   <= {NPIN{1'b0}};
      senoff_q <= {NPIN{1'b0}};
    end else begin
      senoff_q <= senoff;
      for (m = 0; m < NPIN; m = m + 1) begin
        // Synchroniser frozen while sensing is off to save power
        if (!senoff[m]) begin
          sync1_q[m] <= pin_in_i[m] ^ inv[m];
          sync2_q[m] <= sync1_q[m];
          prev_q[m]  <= sync2_q[m];
        end
      end
    end
  end

  // Dead time per pin after a flag; asynchronous pins ignore it
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (n = 0; n < NPIN; n = n + 1) begin
        dead_q[n] <= 2'h0;
      end
    end else begin
      for (n = 0; n < NPIN; n = n + 1) begin
        if (hit[n]) begin
          dead_q[n] <= `GPP_DEAD_CYC;
        end else if (dead_q[n] != 2'h0) begin
          dead_q[n] <= dead_q[n] - 2'h1;
        end
      end
    end
  end

  // Direction and its set, clear and toggle strobes
  always @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= {NPIN{1'b0}};
    end else if (wr_dir) begin
      dir_q <= wr8;
    end else if (wr_drive_enable_set) begin
      dir_q <= dir_q | wr8;
    end else if (wr_drive_enable_clear) begin
      dir_q <= dir_q & ~wr8;
    end else if (wr_drive_enable_toggle) begin
      dir_q <= dir_q ^ wr8;
    end
  end

  // Output level and its set, clear and toggle strobes
  always @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= {NPIN{1'b0}};
    end else if (wr_out) begin
      lvl_q <= wr8;
    end else if (wr_level_set_strobe) begin
      lvl_q <= lvl_q | wr8;
    end else if (wr_level_clear_strobe) begin
      lvl_q <= lvl_q & ~wr8;
    end else if (wr_level_toggle_strobe) begin
      lvl_q <= lvl_q ^ wr8;
    end
  end

  // Per-pin configuration, one byte per pin
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (r = 0; r < NPIN; r = r + 1) begin
        cfg_q[r] <= `GPP_CFG_RST;
      end
    end else if (wr_cfg) begin
      cfg_q[wb_adr_i[4:2]] <= wr8;
    end
  end

  // Event flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= {NPIN{1'b0}};
    end else begin
      flag_q <= flag_d;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero and still acknowledge
  always @* begin
    rd_d = 32'h0000_0000;
    if (widx(wb_adr_i) <= `GPP_OFS_DRIVE_ENABLE_TOGGLE)
      rd_d[7:0] = dir_q;
    else if (widx(wb_adr_i) <= `GPP_OFS_LEVEL_TOGGLE_STROBE)
      rd_d[7:0] = lvl_q;
    else if (widx(wb_adr_i) == `GPP_OFS_IN)
      rd_d[7:0] = sync2_q & ~senoff;
    else if (widx(wb_adr_i) == `GPP_OFS_FLAGS)
      rd_d[7:0] = flag_q;
    else if (widx(wb_adr_i) >= `GPP_OFS_CFG0
             && widx(wb_adr_i) < `GPP_OFS_CFG0 + 8'h08)
      rd_d[7:0] = cfg_q[wb_adr_i[4:2]];
    else if (widx(wb_adr_i) == `GPP_OFS_ALIAS)
      rd_d[7:0] = dir_q;
    else if (widx(wb_adr_i) == `GPP_OFS_ALIAS + 8'h01)
      rd_d[7:0] = lvl_q;
    else if (widx(wb_adr_i) == `GPP_OFS_ALIAS + 8'h02)
      rd_d[7:0] = sync2_q & ~senoff;
    else if (widx(wb_adr_i) == `GPP_OFS_ALIAS + 8'h03)
      rd_d[7:0] = flag_q;
    else if (widx(wb_adr_i) == `GPP_OFS_STAT)
      rd_d[7:0] = {7'h00, irq_o};
  end

  // Bus answer, interrupt request and wake pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_o    <= 1'b0;
      wake_o   <= 1'b0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd_d;
      irq_o    <= |flag_d;
      wake_o   <= |wake_hit;
    end
  end

  // Pad controls; reset leaves every pin released with its input on
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o     <= {NPIN{1'b0}};
      pin_oe_o      <= {NPIN{1'b0}};
      pin_pullup_o  <= {NPIN{1'b0}};
      pin_ibuf_en_o <= {NPIN{1'b1}};
      pin_event_o   <= {NPIN{1'b0}};
    end else begin
      pin_oe_o <= dir_q;
      for (p = 0; p < NPIN; p = p + 1) begin
        pin_out_o[p]     <= lvl_q[p] ^ inv[p];
        pin_pullup_o[p]  <= cfg_q[p][`GPP_CFG_PULL];
        pin_ibuf_en_o[p] <= ~senoff[p];
        // Event takes the raw pin so it needs no running synchroniser
        pin_event_o[p]   <= senoff[p] ? 1'b0
                            : (pin_in_i[p] ^ inv[p]);
      end
    end
  end

endmodule // gpp_port

// file: tb/gpp_port_assertions.sv
// Checker of bus handshake and pin outputs of the GPIO port
`timescale 1ns/100ps
module gpp_port_chk #(parameter NPIN = 8) (
  input wire            clk_i,
  input wire            rst_i,
  input wire            wb_cyc_i,
  input wire            wb_stb_i,
  input wire            wb_we_i,
  input wire [7:0]      wb_adr_i,
  input wire [31:0]     wb_dat_o,
  input wire            wb_ack_o,
  input wire [NPIN-1:0] pin_oe_o,
  input wire [NPIN-1:0] pin_pullup_o,
  input wire [NPIN-1:0] pin_ibuf_en_o,
  input wire [NPIN-1:0] pin_event_o,
  input wire            irq_o,
  input wire            wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_reset_release: assert property
    ($past(rst_i) |-> pin_oe_o == 0 && &pin_ibuf_en_o)
    else $error("pins not released after reset");
  a_event_off: assert property
    ((pin_event_o & ~pin_ibuf_en_o & ~$past(pin_ibuf_en_o)) == 0)
    else $error("event active with input off");
  a_irq_clear: assert property
    ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("irq dropped without a write");
  a_wake_flag: assert property (wake_o |-> irq_o)
    else $error("wake without a flag");
  a_unmapped_zero: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i == 8'hFC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_dir_by_write: assert property
    ($changed(pin_oe_o) |-> $past(wb_cyc_i && wb_we_i))
    else $error("drive enable changed on its own");
  a_pull_by_write: assert property
    ($changed(pin_pullup_o) |-> $past(wb_cyc_i && wb_we_i))
    else $error("pull-up changed on its own");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq: cover property ($rose(irq_o));
  c_ibuf_off: cover property (!(&pin_ibuf_en_o));
endmodule // gpp_port_chk
bind gpp_port gpp_port_chk #(.NPIN(NPIN)) u_gpp_port_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
  .pin_ibuf_en_o(pin_ibuf_en_o), .pin_event_o(pin_event_o), .irq_o(irq_o),
  .wake_o(wake_o));

// file: tb/gpp_pad_model.sv
// Model of the pads and outside circuits of the port
`timescale 1ns/100ps
module gpp_pad_model (
  input  wire       clk_i,
  input  wire [7:0] pin_out_i,
  input  wire [7:0] pin_oe_i,
  input  wire [7:0] pin_pullup_i,
  input  wire [7:0] ext_drv_i,
  input  wire [7:0] ext_lvl_i,
  output reg  [7:0] pad_o
);
  reg [7:0] flt_q = 8'h00;
  // Floating pads wander so a stale value never passes for a real one
  always @(posedge clk_i) flt_q <= ~flt_q;
  always @* pad_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ((ext_drv_i &
    ext_lvl_i) | (~ext_drv_i & (pin_pullup_i | flt_q))));
endmodule // gpp_pad_model

// file: tb/gpp_port_pin_control_bench.sv
// Self-checking bench of the GPIO port
`timescale 1ns/100ps
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %0s exp %h got %h", n, e, g); end end
module gpp_port_pin_control_bench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] dat = 32'h0;
  reg  [7:0]  drv = 8'h00;
  reg  [7:0]  lvl = 8'h00;
  reg  [7:0]  q;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, irq_o, wake;
  integer     wake_cnt = 0;
  integer     wk;
  wire [7:0]  pad, pin_out_o, pin_oe_o, pin_pullup_o, ibuf, ev;
  integer     bad_count = 0;
  integer     total_checks = 0;
  integer     k;
  // Sense codes any, up, down, low and flags after a fall and a rise
  localparam [31:0] CODES = 32'h01020305;
  localparam [31:0] FALL = 32'h10001010;
  localparam [31:0] RISE = 32'h10100010;
  always #5 clk_i = ~clk_i;
  gpp_port u_gpp_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pad),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
    .pin_ibuf_en_o(ibuf), .pin_event_o(ev), .irq_o(irq_o), .wake_o(wake));
  always @(posedge clk_i) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
  gpp_pad_model u_gpp_pad_model (.clk_i(clk_i), .pin_out_i(pin_out_o),
    .pin_oe_i(pin_oe_o), .pin_pullup_i(pin_pullup_o), .ext_drv_i(drv),
    .ext_lvl_i(lvl), .pad_o(pad));
  //////////////////////////////////////////////////////////////////////////
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wb(input wr, input [7:0] a, input [7:0] d);
    integer i;
    begin
      i = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= wr;
      adr <= a;
      dat <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && i < 20) begin
        @(posedge clk_i);
        i = i + 1;
      end
      q = wb_dat_o[7:0];
      cyc <= 1'b0;
      we <= 1'b0;
      if (i >= 20) begin
        bad_count++;
        results;
      end
    end
  endtask
  task rc(input [63:0] n, input [7:0] a, input [7:0] e);
    begin
      wb(1'b0, a, 8'h00);
      `CHK(n, e, q)
    end
  endtask
  task t_dir;
    begin
      `CHK("oe", 8'h00, pin_oe_o)
      `CHK("ibuf", 8'hFF, ibuf)
      rc("unmapped", 8'hFC, 8'h00);
      wb(1'b1, 8'h04, 8'h0F);
      rc("dir", 8'h00, 8'h0F);
      wb(1'b1, 8'h08, 8'h03);
      rc("dir", 8'h00, 8'h0C);
      wb(1'b1, 8'h0C, 8'h05);
      rc("vdir", 8'h80, 8'h09);
      w(2);
      `CHK("oe", 8'h09, pin_oe_o)
    end
  endtask
  task t_out;
    begin
      wb(1'b1, 8'h14, 8'hA5);
      rc("out", 8'h10, 8'hA5);
      wb(1'b1, 8'h18, 8'h21);
      rc("vout", 8'h84, 8'h84);
      wb(1'b1, 8'h1C, 8'h0F);
      rc("out", 8'h10, 8'h8B);
      wb(1'b1, 8'h20, 8'h01);
      rc("out", 8'h10, 8'h8A);
      wb(1'b1, 8'h84, 8'h55);
      wb(1'b1, 8'h04, 8'hFF);
      `CHK("pin_out", 8'h55, pin_out_o)
      w(6);
      rc("in", 8'h20, 8'h55);
      rc("vin", 8'h88, 8'h55);
    end
  endtask
  task t_cfg;
    begin
      wb(1'b1, 8'h40, 8'h04);
      w(4);
      `CHK("ibuf", 8'hFE, ibuf)
      `CHK("event", 8'h54, ev)
      wb(1'b1, 8'h40, 8'h00);
      wb(1'b1, 8'h44, 8'h80);
      rc("cfg1", 8'h44, 8'h80);
      `CHK("pin_out", 8'h57, pin_out_o)
      w(6);
      rc("in", 8'h20, 8'h55);
      wb(1'b1, 8'h48, 8'h08);
      w(2);
      `CHK("pullup", 8'h04, pin_pullup_o)
      wb(1'b1, 8'h44, 8'h00);
    end
  endtask
  task t_sense;
    begin
      drv <= 8'hFF;
      lvl <= 8'h10;
      wb(1'b1, 8'h08, 8'hFF);
      for (k = 0; k < 4; k++) begin
        wb(1'b1, 8'h50, CODES[31-8*k -: 8]);
        wk = wake_cnt;
        w(6);
        wb(1'b1, 8'h24, 8'hFF);
        lvl <= 8'h00;
        w(6);
        rc("flags", 8'h24, FALL[31-8*k -: 8]);
        `CHK("irq", FALL[31-8*k -: 8] != 0, irq_o)
        wb(1'b1, 8'h24, 8'hFF);
        lvl <= 8'h10;
        w(6);
        rc("vflags", 8'h8C, RISE[31-8*k -: 8]);
        `CHK("wake", k == 0 || k == 3, wake_cnt != wk)
      end
      wb(1'b1, 8'h24, 8'hFF);
      w(3);
      `CHK("irq", 1'b0, irq_o)
      rc("flags", 8'h24, 8'h00);
    end
  endtask
  initial begin
    w(12);
    rst_i <= 1'b0;
    t_dir;
    t_out;
    t_cfg;
    t_sense;
    results;
  end
endmodule // gpp_port_pin_control_bench
